// ### logic/faem_matcher.sv
// Behaviour
// - hit needs every configured criterion true
// - ingress port: any, or one port
// - policy compared under 8-bit mask
// - frame type: one of five selections
// - ethernet type needs length/type >= 0x0600
// - arp/ip frames never hit ethernet type
// - deny hit drops the frame
// - permit hit forwards, applies other operations
// - optional rate limiter 1 to 16
// - redirect to configured port when enabled
// - log hit only below 1518 bytes
// - shutdown disables the ingress port
// - shutdown only below 1518 bytes
// - per-entry hit counter counts every hit
// - source address only for etype or arp
// - destination: any, group, all, single, exact
// - up to 512 entries, reserved ones fixed
`timescale 1ns/1ps
`default_nettype none
module faem_matcher
  import faem_pkg::*;
#(
  parameter int N_ENT = DEF_ENTRIES,
  parameter int N_RSVD = DEF_RSVD,
  parameter int CNT_W = DEF_CNT_W,
  parameter int IW = $clog2(N_ENT)
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire faem_frame_t frm,
  output logic res_valid,
  output faem_result_t res,
  input wire logic cfg_wr,
  input wire logic [IW-1:0] cfg_idx,
  input wire logic cfg_valid,
  input wire faem_entry_t cfg_entry,
  input wire logic rsvd_load,
  output logic cfg_err,
  input wire logic cnt_clear,
  input wire logic stat_rd,
  input wire logic [IW-1:0] stat_idx,
  output logic stat_valid,
  output logic [CNT_W-1:0] stat_count
);
  typedef enum logic [2:0] {
    S_CLR = 3'h0,
    S_IDLE = 3'h1,
    S_FETCH = 3'h2,
    S_CMP = 3'h3,
    S_CNT = 3'h4,
    S_DONE = 3'h5
  } faem_state_t;

  localparam logic [IW-1:0] LAST_IDX = IW'(N_ENT - 1);
  localparam logic [IW-1:0] RSVD_IDX = IW'(N_RSVD);

  faem_state_t st_r, st_nxt;
  logic [IW-1:0] idx_r;
  logic [N_ENT-1:0] vld_r;
  faem_frame_t frm_r;
  faem_entry_t cur, ent_r;
  logic [CNT_W-1:0] cnt_rdata;
  logic stat_pend_r;

  // reserved slots are only loadable by the internal protocol loader
  wire cfg_refuse = cfg_wr && (cfg_idx < RSVD_IDX) &&
                    !rsvd_load;
  wire cfg_take = cfg_wr && !cfg_refuse;

  faem_mem #(.W($bits(faem_entry_t)), .DEPTH(N_ENT)) u_ent (
    .core_clk(core_clk),
    .wr_en(cfg_take),
    .wr_addr(cfg_idx),
    .wr_data(cfg_entry),
    .rd_addr(idx_r),
    .rd_data(cur)
  );

  // frame classification
  wire is_ip_arp = frm_r.is_arp || frm_r.is_ipv4 || frm_r.is_ipv6;
  wire is_eth = (frm_r.len_type >= ETYPE_MIN) && !is_ip_arp;
  wire dst_all = &frm_r.dst;
  wire dst_group = frm_r.dst[40] && !dst_all;
  wire dst_single = !frm_r.dst[40];
  wire short_frm = frm_r.len_untagged < OPS_LEN_LIMIT;

  wire port_ok = cur.port_any || (frm_r.port == cur.port_num);
  wire [POL_W-1:0] pol_diff = (frm_r.policy ^ cur.pol_val) & cur.pol_mask;
  wire pol_ok = !cur.pol_spec || (pol_diff == '0);
  wire ft_ok = (cur.ftype == FT_ANY) ||
               (cur.ftype == FT_ETYPE && is_eth) ||
               (cur.ftype == FT_ARP && frm_r.is_arp) ||
               (cur.ftype == FT_IPV4 && frm_r.is_ipv4) ||
               (cur.ftype == FT_IPV6 && frm_r.is_ipv6);
  wire src_used = cur.src_spec &&
                  (cur.ftype == FT_ETYPE || cur.ftype == FT_ARP);
  wire src_ok = !src_used ||
                (frm_r.src == cur.source_hw_address);
  wire dst_ok = (cur.dst_mode == DST_ANY) ||
                (cur.dst_mode == DST_GROUP_CAST && dst_group) ||
                (cur.dst_mode == DST_ALL_CAST && dst_all) ||
                (cur.dst_mode == DST_SINGLE_CAST && dst_single) ||
                (cur.dst_mode == DST_EXACT &&
                 frm_r.dst == cur.destination_hw_address);
  wire match_w = vld_r[idx_r] && port_ok && pol_ok && ft_ok && src_ok &&
                 dst_ok;

  // counter store: shared read port, stats only served when idle
  wire stat_take = (st_r == S_IDLE) && stat_rd && !frm_valid;
  wire [IW-1:0] cnt_raddr = stat_take ? stat_idx : idx_r;
  wire cnt_we = (st_r == S_CLR) || (st_r == S_CNT);
  wire [CNT_W-1:0] cnt_wdata = (st_r == S_CLR) ? '0 :
                               cnt_rdata + CNT_W'(1);

  faem_mem #(.W(CNT_W), .DEPTH(N_ENT)) u_cnt (
    .core_clk(core_clk),
    .wr_en(cnt_we),
    .wr_addr(idx_r),
    .wr_data(cnt_wdata),
    .rd_addr(cnt_raddr),
    .rd_data(cnt_rdata)
  );

  assign frm_ready = (st_r == S_IDLE) && !cnt_clear;
  assign stat_count = cnt_rdata;
  assign stat_valid = stat_pend_r;

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      S_CLR: if (idx_r == LAST_IDX) st_nxt = S_IDLE;
      S_IDLE:
      begin
        if (cnt_clear)
          st_nxt = S_CLR;
        else if (frm_valid)
          st_nxt = S_FETCH;
      end
      S_FETCH: st_nxt = S_CMP;
      S_CMP:
      begin
        if (match_w)
          st_nxt = S_CNT;
        else if (idx_r == LAST_IDX)
          st_nxt = S_DONE;
        else
          st_nxt = S_FETCH;
      end
      S_CNT: st_nxt = S_DONE;
      S_DONE: st_nxt = S_IDLE;
      default: st_nxt = S_CLR;
    endcase
  end

  // verdict, assembled from the winning entry
  faem_result_t res_nxt;
  always_comb
  begin
    res_nxt = '0;
    res_nxt.hit = (st_r == S_CNT);
    res_nxt.idx = 16'(idx_r);
    if (st_r == S_CNT)
    begin
      res_nxt.drop = !ent_r.permit;
      res_nxt.lim_en = ent_r.permit && ent_r.lim_en;
      res_nxt.lim_id = ent_r.lim_id;
      res_nxt.redir_en = ent_r.permit && ent_r.redir_en;
      res_nxt.redir_port = ent_r.redir_port;
      res_nxt.log_req = ent_r.log_en && short_frm;
      res_nxt.shut_req = ent_r.shut_en && short_frm;
      res_nxt.shut_port = frm_r.port;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      st_r <= S_CLR;
      idx_r <= '0;
      vld_r <= '0;
      frm_r <= '0;
      ent_r <= '0;
      res_valid <= 1'b0;
      res <= '0;
      cfg_err <= 1'b0;
      stat_pend_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cfg_err <= cfg_refuse;
      stat_pend_r <= stat_take;
      if (cfg_take)
        vld_r[cfg_idx] <= cfg_valid;
      if (st_r == S_IDLE && frm_valid && !cnt_clear)
        frm_r <= frm;
      if (st_r == S_CMP)
        ent_r <= cur;
      // scan restarts at slot 0 so reserved entries always win
      if (st_r == S_IDLE)
        idx_r <= '0;
      else if (st_r == S_CLR && idx_r != LAST_IDX)
        idx_r <= idx_r + IW'(1);
      else if (st_r == S_CMP && !match_w && idx_r != LAST_IDX)
        idx_r <= idx_r + IW'(1);
      res_valid <= (st_r == S_CNT) || (st_r == S_CMP && st_nxt == S_DONE);
      if (st_r == S_CNT || (st_r == S_CMP && st_nxt == S_DONE))
        res <= res_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_hit_found;
    (st_r == S_CMP) && match_w;
  endsequence
  sequence s_hit_reported;
    (st_r == S_CNT) ##1 (res_valid && res.hit);
  endsequence

  property p_hit_seq;
    s_hit_found |-> ##1 s_hit_reported;
  endproperty
  a_hit_seq: assert property (p_hit_seq)
    else $error("hit not reported");

  // one counter write per hit, tied to the verdict of that same slot
  property p_count_inc;
    (st_r == S_CNT) |->
      (cnt_we && (cnt_wdata == cnt_rdata + CNT_W'(1))) ##1
      (res_valid && res.hit && (res.idx == 16'($past(idx_r))));
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("counter slip");

  property p_port;
    (s_hit_found and (!cur.port_any)) |-> frm_r.port == cur.port_num;
  endproperty
  a_port: assert property (p_port)
    else $error("port mismatch hit");

  property p_policy;
    (s_hit_found and cur.pol_spec) |->
      ((frm_r.policy ^ cur.pol_val) & cur.pol_mask) == '0;
  endproperty
  a_policy: assert property (p_policy)
    else $error("policy mismatch hit");

  property p_etype;
    (s_hit_found and (cur.ftype == FT_ETYPE)) |->
      frm_r.len_type >= ETYPE_MIN && !frm_r.is_arp && !frm_r.is_ipv4 &&
      !frm_r.is_ipv6;
  endproperty
  a_etype: assert property (p_etype)
    else $error("etype hit illegal");

  property p_src;
    (s_hit_found and cur.src_spec and
     (cur.ftype == FT_ETYPE || cur.ftype == FT_ARP)) |->
      frm_r.src == cur.source_hw_address;
  endproperty
  a_src: assert property (p_src)
    else $error("source addr mismatch");

  property p_all_cast;
    (s_hit_found and (cur.dst_mode == DST_ALL_CAST)) |-> &frm_r.dst;
  endproperty
  a_all_cast: assert property (p_all_cast)
    else $error("not all-cast");

  property p_deny;
    res_valid && res.hit && !$past(ent_r.permit) |->
      res.drop && !res.redir_en && !res.lim_en;
  endproperty
  a_deny: assert property (p_deny)
    else $error("deny not dropped");

  property p_permit;
    res_valid && res.hit && $past(ent_r.permit, 1) |-> !res.drop;
  endproperty
  a_permit: assert property (p_permit)
    else $error("permit dropped");

  property p_short_ops;
    res_valid && (res.log_req || res.shut_req) |->
      frm_r.len_untagged < OPS_LEN_LIMIT && res.shut_port == frm_r.port;
  endproperty
  a_short_ops: assert property (p_short_ops)
    else $error("long frame op");

  property p_rsvd;
    cfg_wr && cfg_idx < RSVD_IDX && !rsvd_load |-> ##1 cfg_err;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved write taken");
endmodule
`default_nettype wire

// ### logic/faem_mem.sv
`timescale 1ns/1ps
`default_nettype none
module faem_mem #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ### logic/faem_pkg.sv
`default_nettype none
package faem_pkg;
  localparam int PORT_W = 5;
  localparam int POL_W = 8;
  localparam int ADDR_W = 48;
  localparam int LIM_W = 4;
  localparam logic [15:0] ETYPE_MIN = 16'h0600;
  localparam logic [15:0] OPS_LEN_LIMIT = 16'h05ee;
  localparam int DEF_ENTRIES = 512;
  localparam int DEF_RSVD = 4;
  localparam int DEF_CNT_W = 32;

  typedef enum logic [2:0] {
    FT_ANY = 3'h0,
    FT_ETYPE = 3'h1,
    FT_ARP = 3'h2,
    FT_IPV4 = 3'h3,
    FT_IPV6 = 3'h4
  } faem_ftype_t;

  typedef enum logic [2:0] {
    DST_ANY = 3'h0,
    DST_GROUP_CAST = 3'h1,
    DST_ALL_CAST = 3'h2,
    DST_SINGLE_CAST = 3'h3,
    DST_EXACT = 3'h4
  } faem_dst_mode_t;

  typedef struct packed {
    logic port_any;
    logic [PORT_W-1:0] port_num;
    logic pol_spec;
    logic [POL_W-1:0] pol_val;
    logic [POL_W-1:0] pol_mask;
    faem_ftype_t ftype;
    logic permit;
    logic lim_en;
    logic [LIM_W-1:0] lim_id;
    logic redir_en;
    logic [PORT_W-1:0] redir_port;
    logic log_en;
    logic shut_en;
    logic src_spec;
    logic [ADDR_W-1:0] source_hw_address;
    faem_dst_mode_t dst_mode;
    logic [ADDR_W-1:0] destination_hw_address;
  } faem_entry_t;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [POL_W-1:0] policy;
    logic [15:0] len_type;
    logic is_arp;
    logic is_ipv4;
    logic is_ipv6;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [15:0] len_untagged;
  } faem_frame_t;

  typedef struct packed {
    logic hit;
    logic [15:0] idx;
    logic drop;
    logic lim_en;
    logic [LIM_W-1:0] lim_id;
    logic redir_en;
    logic [PORT_W-1:0] redir_port;
    logic log_req;
    logic shut_req;
    logic [PORT_W-1:0] shut_port;
  } faem_result_t;
endpackage
`default_nettype wire

// ### sim/faem_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
module faem_frame_src
  import faem_pkg::*;
(
  input wire logic core_clk,
  input wire logic frm_ready,
  output logic frm_valid,
  output faem_frame_t frm
);
  initial
  begin
    frm_valid = 1'b0;
    frm = '0;
  end

  // held until the taking edge; scrambled after release so no stale match
  task automatic send(input faem_frame_t f);
    @(negedge core_clk);
    frm_valid = 1'b1;
    frm = f;
    while (frm_ready !== 1'b1)
      @(negedge core_clk);
    @(negedge core_clk);
    frm_valid = 1'b0;
    frm = ~f;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_frame_access_entry_matcher.sv
`timescale 1ns/1ps
`default_nettype none
module tb_frame_access_entry_matcher
  import faem_pkg::*;
  ();
  localparam logic [47:0] SA = 48'h0a1b2c3d4e5f;
  localparam logic [47:0] DB = 48'h02aabbccdd01;
  localparam logic [47:0] DF = 48'hffffffffffff;
  localparam logic [47:0] D1 = 48'h001122334455;
  localparam logic [47:0] GC = 48'h01005e000001;
  logic core_clk = 0, rstn = 0, cfg_wr = 0, cfg_valid = 0, rsvd_load = 0;
  logic cnt_clear = 0, stat_rd = 0, ce;
  logic frm_valid, frm_ready, res_valid, cfg_err, stat_valid;
  logic [2:0] cfg_idx = 0, stat_idx = 0;
  logic [31:0] stat_count;
  faem_frame_t frm;
  faem_result_t res;
  faem_entry_t cfg_entry = '0;
  int errors = 0, tests_run = 0, cyc = 0;

  faem_matcher #(.N_ENT(8), .N_RSVD(2)) u_faem_matcher (
    .core_clk(core_clk), .rstn(rstn), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm(frm), .res_valid(res_valid), .res(res),
    .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_valid(cfg_valid),
    .cfg_entry(cfg_entry), .rsvd_load(rsvd_load), .cfg_err(cfg_err),
    .cnt_clear(cnt_clear), .stat_rd(stat_rd), .stat_idx(stat_idx),
    .stat_valid(stat_valid), .stat_count(stat_count));
  faem_frame_src u_faem_frame_src (.core_clk(core_clk),
    .frm_ready(frm_ready), .frm_valid(frm_valid), .frm(frm));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      errors++;
      complete_run;
    end
  end

  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // pt {any,port}, pl {spec,val,mask}, ac {permit,lim_en,lim,redir,port}
  function automatic faem_entry_t ent(input logic [5:0] pt,
      input logic [16:0] pl, input faem_ftype_t ft, input logic [11:0] ac,
      input logic [1:0] ls, input logic [48:0] s, input faem_dst_mode_t dm,
      input logic [47:0] d);
    return '{pt[5], pt[4:0], pl[16], pl[15:8], pl[7:0], ft, ac[11], ac[10],
      ac[9:6], ac[5], ac[4:0], ls[1], ls[0], s[48], s[47:0], dm, d};
  endfunction

  function automatic faem_frame_t fr(input logic [4:0] p,
      input logic [7:0] pol, input logic [15:0] lt, input logic [2:0] k,
      input logic [47:0] s, input logic [47:0] d, input logic [15:0] len);
    return '{p, pol, lt, k[2], k[1], k[0], s, d, len};
  endfunction

  task automatic wr(input logic [2:0] i, input faem_entry_t e,
      input logic v = 1'b1);
    @(negedge core_clk);
    cfg_wr = 1;
    cfg_idx = i;
    cfg_valid = v;
    cfg_entry = e;
    @(negedge core_clk);
    cfg_wr = 0;
  endtask

  // i of 4'hf means no entry may hit; d is {drop,log,shutdown}
  task automatic vd(input faem_frame_t f, input logic [3:0] i,
      input logic [2:0] d);
    int n;
    n = 0;
    u_faem_frame_src.send(f);
    while (res_valid !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    cmp(res_valid, 1'b1);
    if (i == 4'hf)
      cmp(res.hit, 1'b0);
    else
      cmp({res.hit, res.idx[3:0], res.drop, res.log_req, res.shut_req},
        {1'b1, i, d});
  endtask

  task automatic rdc(input logic [2:0] i, input logic [31:0] x);
    int n;
    n = 0;
    while (frm_ready !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    stat_rd = 1;
    stat_idx = i;
    @(negedge core_clk);
    stat_rd = 0;
    while (stat_valid !== 1'b1 && n < 44)
    begin
      @(negedge core_clk);
      n++;
    end
    cmp({stat_valid, stat_count}, {1'b1, x});
  endtask

  initial
  begin
    repeat (20) @(negedge core_clk);
    rstn = 1;
    wr(2, ent(6'h20, 0, FT_ETYPE, 12'h420, 2'h3, {1'b1, SA}, DST_ANY, 0));
    wr(3, ent(6'h03, 17'h1a5f0, FT_IPV4, 12'hfe5, 0, 0, DST_ALL_CAST, 0));
    wr(4, ent(6'h20, 0, FT_ARP, 12'h800, 0, 0, DST_GROUP_CAST, 0));
    wr(5, ent(6'h20, 0, FT_IPV6, 12'h800, 0, 0, DST_EXACT, DB));
    wr(6, ent(6'h07, 0, FT_ANY, 12'h800, 0, 0, DST_SINGLE_CAST, 0));
    rdc(2, 0);
    vd(fr(1, 0, 16'h0600, 0, SA, D1, 16'h05ed), 2, 3'h7);
    cmp({res.lim_en, res.redir_en, res.shut_port}, 7'h01);
    vd(fr(1, 0, 16'h05ff, 0, SA, D1, 16'h0040), 4'hf, 0);
    vd(fr(1, 0, 16'h0600, 0, ~SA, D1, 16'h0040), 4'hf, 0);
    vd(fr(1, 0, 16'h0600, 0, SA, D1, 16'h05ee), 2, 3'h4);
    $display("test etype done");
    vd(fr(1, 0, 16'h0806, 3'h4, SA, D1, 16'h0040), 4'hf, 0);
    vd(fr(1, 0, 16'h0806, 3'h4, SA, GC, 16'h0040), 4, 0);
    vd(fr(3, 8'ha7, 16'h0800, 3'h2, SA, DF, 16'h0040), 3, 0);
    cmp({res.lim_en, res.lim_id, res.redir_en, res.redir_port},
      11'h7e5);
    vd(fr(3, 8'hb5, 16'h0800, 3'h2, SA, DF, 16'h0040), 4'hf, 0);
    vd(fr(4, 8'ha7, 16'h0800, 3'h2, SA, DF, 16'h0040), 4'hf, 0);
    vd(fr(2, 0, 16'h86dd, 3'h1, SA, DB, 16'h0040), 5, 0);
    vd(fr(2, 0, 16'h86dd, 3'h1, SA, DB ^ 1, 16'h0040), 4'hf, 0);
    rdc(2, 2);
    $display("test criteria done");
    wr(0, ent(6'h20, 0, FT_ANY, 12'h000, 0, 0, DST_ANY, 0));
    ce = cfg_err;
    repeat (2) @(negedge core_clk) ce |= cfg_err;
    cmp(ce, 1'b1);
    wr(7, ent(6'h20, 0, FT_ANY, 12'h800, 0, 0, DST_ANY, 0));
    vd(fr(7, 0, 16'h0800, 3'h2, SA, D1, 16'h0040), 6, 0);
    vd(fr(7, 0, 16'h0800, 3'h2, SA, GC, 16'h0040), 7, 0);
    rsvd_load = 1;
    wr(1, ent(6'h20, 0, FT_ANY, 12'h000, 0, 0, DST_ANY, 0));
    vd(fr(7, 0, 16'h0800, 3'h2, SA, D1, 16'h0040), 1, 3'h4);
    wr(1, '0, 1'b0);
    vd(fr(7, 0, 16'h0800, 3'h2, SA, D1, 16'h0040), 6, 0);
    rdc(6, 2);
    cnt_clear = 1;
    @(negedge core_clk);
    cnt_clear = 0;
    rdc(2, 0);
    $display("test order done");
    complete_run;
  end
endmodule
`default_nettype wire
